/* File: fec_pkg.sv */
`default_nettype none
package fec_pkg;

  // operand carrier width, widest format
  localparam int FEC_OP_W       = 80;
  localparam int FEC_EXP_W      = 15;
  localparam int FEC_FRAC_W     = 63;
  localparam int FEC_UEXP_W     = 17;

  // format select codes
  localparam logic [1:0] FEC_FMT_SINGLE = 2'h0;
  localparam logic [1:0] FEC_FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FEC_FMT_EXT    = 2'h2;

  // single layout
  localparam int FEC_SGL_SIGN   = 31;
  localparam int FEC_SGL_EXP_HI = 30;
  localparam int FEC_SGL_EXP_LO = 23;
  localparam int FEC_SGL_FRAC_W = 23;

  // double layout
  localparam int FEC_DBL_SIGN   = 63;
  localparam int FEC_DBL_EXP_HI = 62;
  localparam int FEC_DBL_EXP_LO = 52;
  localparam int FEC_DBL_FRAC_W = 52;

  // double extended layout, explicit integer bit
  localparam int FEC_EXT_SIGN   = 79;
  localparam int FEC_EXT_EXP_HI = 78;
  localparam int FEC_EXT_EXP_LO = 64;
  localparam int FEC_EXT_INT    = 63;
  localparam int FEC_EXT_FRAC_HI = 62;

  // exponent biases
  localparam logic [FEC_UEXP_W-1:0] FEC_SGL_BIAS = 17'h0007f;
  localparam logic [FEC_UEXP_W-1:0] FEC_DBL_BIAS = 17'h003ff;
  localparam logic [FEC_UEXP_W-1:0] FEC_EXT_BIAS = 17'h03fff;

  // memory footprints
  localparam logic [3:0] FEC_SGL_BYTES = 4'h4;
  localparam logic [3:0] FEC_DBL_BYTES = 4'h8;
  localparam logic [3:0] FEC_EXT_BYTES = 4'ha;
  localparam logic [9:0] FEC_SGL_BE    = 10'h00f;
  localparam logic [9:0] FEC_DBL_BE    = 10'h0ff;
  localparam logic [9:0] FEC_EXT_BE    = 10'h3ff;

  // fraction pattern of the indefinite value, left aligned
  localparam logic [FEC_FRAC_W-1:0] FEC_INDEF_FRAC = 63'h4000000000000000;

  // fields of one operand, fraction left aligned to bit 62
  typedef struct packed {
    logic                  sign;
    logic [FEC_EXP_W-1:0]  exp;
    logic                  exp_zero;
    logic                  exp_max;
    logic                  int_bit;
    logic [FEC_FRAC_W-1:0] frac;
    logic [FEC_UEXP_W-1:0] bias;
  } fec_fields_t;

  // class flags, at most one set, except indefinite, which is set together with qnan
  typedef struct packed {
    logic zero;
    logic denormal;
    logic normal;
    logic infinity;
    logic snan;
    logic qnan;
    logic indefinite;
    logic invalid;
  } fec_class_t;

endpackage
`default_nettype wire

/* File: fec_split.sv */
`timescale 1ns/1ps
`default_nettype none
module fec_split (
  input  wire logic [1:0]                   fmt,
  input  wire logic [fec_pkg::FEC_OP_W-1:0] operand,
  output fec_pkg::fec_fields_t              fields,
  output logic                              fmt_bad
);

  localparam int SGL_PAD = fec_pkg::FEC_FRAC_W - fec_pkg::FEC_SGL_FRAC_W;
  localparam int DBL_PAD = fec_pkg::FEC_FRAC_W - fec_pkg::FEC_DBL_FRAC_W;

  // pull sign, exponent, integer bit and fraction per format
  always_comb begin
    fields  = '0;
    fmt_bad = 1'b0;
    case (fmt)
      fec_pkg::FEC_FMT_SINGLE: begin
        fields.sign     = operand[fec_pkg::FEC_SGL_SIGN];
        fields.exp      = 15'(operand[fec_pkg::FEC_SGL_EXP_HI:fec_pkg::FEC_SGL_EXP_LO]);
        fields.exp_zero = ~|operand[fec_pkg::FEC_SGL_EXP_HI:fec_pkg::FEC_SGL_EXP_LO];
        fields.exp_max  = &operand[fec_pkg::FEC_SGL_EXP_HI:fec_pkg::FEC_SGL_EXP_LO];
        fields.int_bit  = ~fields.exp_zero;
        fields.frac     = {operand[fec_pkg::FEC_SGL_FRAC_W-1:0], {SGL_PAD{1'b0}}};
        fields.bias     = fec_pkg::FEC_SGL_BIAS;
      end
      fec_pkg::FEC_FMT_DOUBLE: begin
        fields.sign     = operand[fec_pkg::FEC_DBL_SIGN];
        fields.exp      = 15'(operand[fec_pkg::FEC_DBL_EXP_HI:fec_pkg::FEC_DBL_EXP_LO]);
        fields.exp_zero = ~|operand[fec_pkg::FEC_DBL_EXP_HI:fec_pkg::FEC_DBL_EXP_LO];
        fields.exp_max  = &operand[fec_pkg::FEC_DBL_EXP_HI:fec_pkg::FEC_DBL_EXP_LO];
        fields.int_bit  = ~fields.exp_zero;
        fields.frac     = {operand[fec_pkg::FEC_DBL_FRAC_W-1:0], {DBL_PAD{1'b0}}};
        fields.bias     = fec_pkg::FEC_DBL_BIAS;
      end
      fec_pkg::FEC_FMT_EXT: begin
        fields.sign     = operand[fec_pkg::FEC_EXT_SIGN];
        fields.exp      = operand[fec_pkg::FEC_EXT_EXP_HI:fec_pkg::FEC_EXT_EXP_LO];
        fields.exp_zero = ~|operand[fec_pkg::FEC_EXT_EXP_HI:fec_pkg::FEC_EXT_EXP_LO];
        fields.exp_max  = &operand[fec_pkg::FEC_EXT_EXP_HI:fec_pkg::FEC_EXT_EXP_LO];
        fields.int_bit  = operand[fec_pkg::FEC_EXT_INT];
        fields.frac     = operand[fec_pkg::FEC_EXT_FRAC_HI:0];
        fields.bias     = fec_pkg::FEC_EXT_BIAS;
      end
      default: begin
        fmt_bad = 1'b1; // unused select code
      end
    endcase
  end

endmodule // fec_split
`default_nettype wire

/* File: fec_classifier.sv */
`timescale 1ns/1ps
`default_nettype none
module fec_classifier (
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  input  wire logic                             in_valid,
  input  wire logic [1:0]                       in_fmt,
  input  wire logic [fec_pkg::FEC_OP_W-1:0]     in_operand,
  output logic                                  out_valid,
  output fec_pkg::fec_class_t                   out_class,
  output logic                                  out_fmt_bad,
  output logic                                  out_sign,
  output logic [fec_pkg::FEC_EXP_W-1:0]         out_exp_biased,
  output logic signed [fec_pkg::FEC_UEXP_W-1:0] out_exp_unbiased,
  output logic [fec_pkg::FEC_FRAC_W:0]          out_significand,
  output logic [3:0]                            out_mem_bytes,
  output logic [9:0]                            out_mem_byte_en,
  output logic [fec_pkg::FEC_OP_W-1:0]          out_mem_data
);

  // reset release synchroniser
  logic [1:0] rst_sync;
  logic [1:0] next_rst_sync;
  logic       rst_n;

  // shift a one in behind the released reset
  always_comb begin
    next_rst_sync = {rst_sync[0], 1'b1};
  end

  // reset release flops, cleared at once by the pin
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= next_rst_sync;
    end
  end

  assign rst_n = rst_sync[1];

  // unbias a zero-extended exponent
  function automatic logic signed [fec_pkg::FEC_UEXP_W-1:0] unbias(
    input logic [fec_pkg::FEC_EXP_W-1:0]  exp,
    input logic [fec_pkg::FEC_UEXP_W-1:0] bias
  );
    logic [fec_pkg::FEC_UEXP_W-1:0] wide;
    wide   = {2'h0, exp};
    unbias = $signed(wide - bias);
  endfunction

  // byte count and byte enables of one format in memory
  function automatic logic [13:0] footprint(
    input logic [1:0] fmt
  );
    case (fmt)
      fec_pkg::FEC_FMT_SINGLE: begin
        footprint = {fec_pkg::FEC_SGL_BYTES, fec_pkg::FEC_SGL_BE};
      end
      fec_pkg::FEC_FMT_DOUBLE: begin
        footprint = {fec_pkg::FEC_DBL_BYTES, fec_pkg::FEC_DBL_BE};
      end
      fec_pkg::FEC_FMT_EXT: begin
        footprint = {fec_pkg::FEC_EXT_BYTES, fec_pkg::FEC_EXT_BE};
      end
      default: begin
        footprint = 14'h0000; // unused select code moves nothing
      end
    endcase
  endfunction

  // widen byte enables into a bit mask, byte i at bits 8i+7 to 8i
  function automatic logic [fec_pkg::FEC_OP_W-1:0] lane_bits(
    input logic [9:0] byte_en
  );
    lane_bits = '0;
    for (int i = 0; i < 10; i++) begin
      lane_bits[i*8 +: 8] = {8{byte_en[i]}};
    end
  endfunction

  // field extraction
  fec_pkg::fec_fields_t fields;
  logic                 fmt_bad;

  fec_split u_split (
    .fmt     (in_fmt),
    .operand (in_operand),
    .fields  (fields),
    .fmt_bad (fmt_bad)
  );

  // classification terms
  logic                frac_nz;
  logic                is_ext;
  logic                ext_bad;
  fec_pkg::fec_class_t cls;

  // decide the one class of the operand
  always_comb begin
    frac_nz = |fields.frac;
    is_ext  = (in_fmt == fec_pkg::FEC_FMT_EXT);
    // explicit integer bit out of step with the exponent
    ext_bad = is_ext &&
              ((fields.exp_zero && fields.int_bit) ||
               (!fields.exp_zero && !fields.int_bit));
    cls = '0;
    if (fmt_bad || ext_bad) begin
      cls.invalid = 1'b1;
    end else if (fields.exp_max) begin
      if (!frac_nz) begin
        cls.infinity = 1'b1;
      end else if (fields.frac[fec_pkg::FEC_FRAC_W-1]) begin
        cls.qnan       = 1'b1;
        cls.indefinite = fields.sign &&
                         (fields.frac == fec_pkg::FEC_INDEF_FRAC);
      end else begin
        cls.snan = 1'b1;
      end
    end else if (fields.exp_zero) begin
      if (frac_nz) begin
        cls.denormal = 1'b1;
      end else begin
        cls.zero = 1'b1;
      end
    end else begin
      cls.normal = 1'b1;
    end
  end

  // next values of the result registers
  logic                                  next_valid;
  fec_pkg::fec_class_t                   next_class;
  logic                                  next_fmt_bad;
  logic                                  next_sign;
  logic [fec_pkg::FEC_EXP_W-1:0]         next_exp_biased;
  logic signed [fec_pkg::FEC_UEXP_W-1:0] next_exp_unbiased;
  logic [fec_pkg::FEC_FRAC_W:0]          next_significand;
  logic [3:0]                            next_mem_bytes;
  logic [9:0]                            next_mem_byte_en;
  logic [fec_pkg::FEC_OP_W-1:0]          next_mem_data;

  // byte lane mask of the memory image
  logic [fec_pkg::FEC_OP_W-1:0]          lane_mask;

  // result strobe: one cycle for each taken operand
  always_comb begin
    next_valid = in_valid;
  end

  // result strobe register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= next_valid;
    end
  end

  // load a new result on each valid operand, hold otherwise
  always_comb begin
    // hold the last result by default
    next_class        = out_class;
    next_fmt_bad      = out_fmt_bad;
    next_sign         = out_sign;
    next_exp_biased   = out_exp_biased;
    next_exp_unbiased = out_exp_unbiased;
    next_significand  = out_significand;
    next_mem_bytes    = out_mem_bytes;
    next_mem_byte_en  = out_mem_byte_en;
    next_mem_data     = out_mem_data;
    lane_mask         = '0;
    if (in_valid) begin
      // take every field of the new operand
      next_class        = cls;
      next_fmt_bad      = fmt_bad;
      next_sign         = fields.sign;
      next_exp_biased   = fields.exp;
      next_exp_unbiased = unbias(fields.exp, fields.bias);
      next_significand  = {fields.int_bit, fields.frac};
      // byte footprint, lowest byte at lowest address
      {next_mem_bytes, next_mem_byte_en} = footprint(in_fmt);
      // widen byte enables into a bit mask
      lane_mask     = lane_bits(next_mem_byte_en);
      next_mem_data = in_operand & lane_mask;
    end
  end

  // result registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_class        <= '0;
      out_fmt_bad      <= 1'b0;
      out_sign         <= 1'b0;
      out_exp_biased   <= '0;
      out_exp_unbiased <= '0;
      out_significand  <= '0;
      out_mem_bytes    <= 4'h0;
      out_mem_byte_en  <= 10'h000;
      out_mem_data     <= '0;
    end else begin
      out_class        <= next_class;
      out_fmt_bad      <= next_fmt_bad;
      out_sign         <= next_sign;
      out_exp_biased   <= next_exp_biased;
      out_exp_unbiased <= next_exp_unbiased;
      out_significand  <= next_significand;
      out_mem_bytes    <= next_mem_bytes;
      out_mem_byte_en  <= next_mem_byte_en;
      out_mem_data     <= next_mem_data;
    end
  end

endmodule // fec_classifier
`default_nettype wire

/* File: fec_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// downstream datapath stage: takes each one-cycle result pulse
module fec_sink (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic out_valid,
  output var  int   count
);
  // count results taken, cleared by reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) count <= 0;
    else if (out_valid) count <= count + 1;
  end
endmodule // fec_sink
`default_nettype wire

/* File: fec_classifier_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fec_classifier_chk (
  input wire logic                sys_clk,
  input wire logic                arst_n,
  input wire logic                in_valid,
  input wire logic [1:0]          in_fmt,
  input wire logic [79:0]         in_operand,
  input wire logic                out_valid,
  input wire fec_pkg::fec_class_t out_class,
  input wire logic                out_sign,
  input wire logic signed [16:0]  out_exp_unbiased,
  input wire logic [63:0]         out_significand,
  input wire logic [3:0]          out_mem_bytes,
  input wire logic [9:0]          out_mem_byte_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // operand field views per format
  wire logic sgl = in_valid && in_fmt == 2'h0;
  wire logic dbl = in_valid && in_fmt == 2'h1;
  wire logic ext = in_valid && in_fmt == 2'h2;
  wire logic ext_max = &in_operand[78:64];
  // one taken operand gives one result a cycle later
  sequence s_take;
    in_valid ##1 out_valid;
  endsequence
  take_one_a: assert property (in_valid |-> s_take) else $error("result missing");
  quiet_gap_a: assert property (!in_valid |=> !out_valid) else $error("stray result");
  ext_snan_a: assert property (ext && ext_max && in_operand[63] && !in_operand[62]
    && |in_operand[61:0] |=> out_class.snan) else $error("ext snan missed");
  inf_no_nan_a: assert property (sgl && &in_operand[30:23] && in_operand[22:0] == 23'h0
    |=> out_class.infinity && !out_class.snan && !out_class.qnan) else $error("inf wrong");
  sgl_int_a: assert property (sgl |=> out_significand[63] == |$past(in_operand[30:23]))
    else $error("hidden bit wrong");
  dbl_bias_a: assert property (dbl |=> out_exp_unbiased
    == 17'($past(in_operand[62:52])) - 17'h003ff) else $error("double bias wrong");
  ext_bytes_a: assert property (ext |=> out_mem_bytes == 4'ha && out_mem_byte_en == 10'h3ff)
    else $error("ext footprint wrong");
  ext_signif_a: assert property (ext |=> out_significand == $past(in_operand[63:0]))
    else $error("ext significand wrong");
  ext_int_a: assert property (ext && in_operand[78:64] == 15'h0 && in_operand[63]
    |=> out_class.invalid) else $error("ext int bit ignored");
  dbl_sign_a: assert property (dbl |=> out_sign == $past(in_operand[63]))
    else $error("sign wrong");
endmodule // fec_classifier_chk
bind fec_classifier fec_classifier_chk i_fec_classifier_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .in_valid(in_valid), .in_fmt(in_fmt), .in_operand(in_operand),
  .out_valid(out_valid), .out_class(out_class), .out_sign(out_sign),
  .out_exp_unbiased(out_exp_unbiased), .out_significand(out_significand),
  .out_mem_bytes(out_mem_bytes), .out_mem_byte_en(out_mem_byte_en));
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                sys_clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                in_valid = 1'b0;
  logic [1:0]          in_fmt = 2'h0;
  logic [79:0]         in_operand = 80'h0;
  logic                out_valid;
  logic                out_fmt_bad;
  logic                out_sign;
  fec_pkg::fec_class_t out_class;
  logic [14:0]         out_exp_biased;
  logic signed [16:0]  out_exp_unbiased;
  logic [63:0]         out_significand;
  logic [3:0]          out_mem_bytes;
  logic [9:0]          out_mem_byte_en;
  logic [79:0]         out_mem_data;
  int                  seen;
  int                  sent = 0;
  int                  fail_count = 0;
  int                  tests_run = 0;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  fec_classifier i_fec_classifier (.sys_clk(sys_clk), .arst_n(arst_n), .in_valid(in_valid),
    .in_fmt(in_fmt), .in_operand(in_operand), .out_valid(out_valid), .out_class(out_class),
    .out_fmt_bad(out_fmt_bad), .out_sign(out_sign), .out_exp_biased(out_exp_biased),
    .out_exp_unbiased(out_exp_unbiased), .out_significand(out_significand),
    .out_mem_bytes(out_mem_bytes), .out_mem_byte_en(out_mem_byte_en),
    .out_mem_data(out_mem_data));
  fec_sink i_fec_sink (.sys_clk(sys_clk), .arst_n(arst_n), .out_valid(out_valid), .count(seen));
  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one operand, result looked at in its single valid cycle
  task automatic cls(input logic [1:0] f, input logic [79:0] op, input logic [7:0] c);
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_fmt <= f;
    in_operand <= op;
    @(posedge sys_clk);
    in_valid <= 1'b0;
    sent++;
    #1;
    check("valid", 80'h1, 80'(out_valid));
    check("class", 80'(c), 80'(out_class));
  endtask
  task automatic t_single;
    cls(2'h0, 80'hffffffffffff3f800000, 8'h20);
    check("biased", 80'h7f, 80'(out_exp_biased));
    check("unbiased", 80'h0, 80'(out_exp_unbiased));
    check("signif", 80'h8000000000000000, 80'(out_significand));
    check("bytes", 80'h4, 80'(out_mem_bytes));
    check("byte_en", 80'h00f, 80'(out_mem_byte_en));
    check("mem", 80'h3f800000, out_mem_data);
    cls(2'h0, 80'h0, 8'h80);
    check("zero signif", 80'h0, 80'(out_significand));
    cls(2'h0, 80'h7f800000, 8'h10);
    cls(2'h0, 80'h7f800001, 8'h08);
    cls(2'h0, 80'h7fc00000, 8'h04);
    cls(2'h0, 80'hffc00000, 8'h06);
  endtask
  task automatic t_double;
    cls(2'h1, 80'hffff8000000000000001, 8'h40);
    check("sign", 80'h1, 80'(out_sign));
    check("unbiased", 80'h1fc01, 80'($unsigned(out_exp_unbiased)));
    check("signif", 80'h800, 80'(out_significand));
    check("bytes", 80'h8, 80'(out_mem_bytes));
    check("mem", 80'h8000000000000001, out_mem_data);
  endtask
  task automatic t_ext;
    cls(2'h2, 80'h7fff8000000000000000, 8'h10);
    cls(2'h2, 80'h7fffa000000000000000, 8'h08);
    cls(2'h2, 80'h7fff4000000000000000, 8'h01);
    cls(2'h2, 80'h00008000000000000000, 8'h01);
    cls(2'h2, 80'h40000000000000000001, 8'h01);
    cls(2'h2, 80'hffffc000000000000000, 8'h06);
    cls(2'h2, 80'hbfff8000000000000001, 8'h20);
    check("biased", 80'h3fff, 80'(out_exp_biased));
    check("unbiased", 80'h0, 80'(out_exp_unbiased));
    check("signif", 80'h8000000000000001, 80'(out_significand));
    check("byte_en", 80'h3ff, 80'(out_mem_byte_en));
    check("mem", 80'hbfff8000000000000001, out_mem_data);
  endtask
  // back to back: unused select code then a single operand
  task automatic t_b2b;
    @(posedge sys_clk);
    in_valid <= 1'b1;
    in_fmt <= 2'h3;
    in_operand <= 80'h3f800000;
    @(posedge sys_clk);
    in_fmt <= 2'h0;
    #1;
    check("bad class", 80'h01, 80'(out_class));
    check("fmt_bad", 80'h1, 80'(out_fmt_bad));
    check("bad bytes", 80'h0, 80'(out_mem_bytes));
    @(posedge sys_clk);
    in_valid <= 1'b0;
    sent += 2;
    #1;
    check("b2b valid", 80'h1, 80'(out_valid));
    check("b2b class", 80'h20, 80'(out_class));
    @(posedge sys_clk);
    #1;
    check("results", 80'(sent), 80'(seen));
    check("idle valid", 80'h0, 80'(out_valid));
    check("held class", 80'h20, 80'(out_class));
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_single;
    t_double;
    t_ext;
    t_b2b;
    tally_and_finish;
  end
  // watchdog
  initial begin
    #80000;
    fail_count++;
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
